// [pkg/smbus_dac_map.vh]
// Constants for the two-wire DAC receiver: addresses, command bits, frame counts.
// Assumes inclusion by the receiver module and the bench; no logic here.
`ifndef SMBUS_DAC_MAP_VH
`define SMBUS_DAC_MAP_VH
`define SYNC_ADDR 7'h7E
`define OWN_ADDR_DEFAULT 7'h20
`define CMD_SYNC_MODE_BIT 0
`define CMD_POWER_DOWN_BIT 1
`define CMD_REF_SEL_BIT 2
`define CMD_RESET 3'h0
`define CODE_RESET 10'h000
`define BITS_PER_BYTE 4'h8
`define ACK_SLOT 4'h9
`endif

// [hw/smbus_dac_rx.v]
// Receive-only two-wire slave front end of a 10-bit DAC: command, word write, sync quick command.
// Assumes SCL and SDA are asynchronous pins; both are double-registered on i_clk before any use.
// Operation
// - Low data byte bits 7..0 are DAC code bits 7..0.
// - High data byte: only bits 1,0 used as code bits 9,8.
// - Send Byte frame updates command settings; it moves the code only at STOP when it clears sync mode over a pending word.
// - START/STOP after command ack, before last ack: keep command, drop data.
// - START/STOP before command ack: discard command, keep old settings.
// - Respond also to shared sync address 1111 110.
// - Sync access is quick command: address, option bit, ack, stop.
// - Option bit 1 acts only when sync-update mode was set.
// - Valid sync update loads output latches at SCL rise in ack.
// - Option bit 0 clears the device regardless of sync mode.
// - Clear resets the input and output code latches at SCL rise during sync ack; command bits are kept.
// - Word write: command, low, high bytes, each acked and latched.
// - Sync mode clear: STOP copies input registers to outputs.
// - Command bit 0 selects sync-update mode, reset value 0.
// - Bit 1 power-down, bit 2 reference select; power-down applies on STOP.
`timescale 1ns/1ps
`include "smbus_dac_map.vh"
module smbus_dac_rx #(
   parameter [6:0] OWN_ADDR = `OWN_ADDR_DEFAULT
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_scl,
   input wire i_sda,
   output reg o_sda_out,
   output reg o_sda_oe,
   output reg [9:0] o_dac_code,
   output reg o_power_down,
   output reg o_internal_ref_select,
   output reg o_sync_update_mode
);
   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_ADDR = 5'h02;
   localparam [4:0] ST_CMD = 5'h04;
   localparam [4:0] ST_DATA = 5'h08;
   localparam [4:0] ST_SKIP = 5'h10;
   // Idle waits for START; ADDR, CMD and DATA count bits and the ack slot
   // SKIP ignores everything up to the next START or STOP
   // Only START and STOP leave SKIP, so a foreign frame can never be half-decoded

   // Pin synchronisers plus one delayed copy for edge finding
   reg scl_s1_q;
   reg scl_s2_q;
   reg scl_prev_q;
   reg sda_s1_q;
   reg sda_s2_q;
   reg sda_prev_q;
   reg [4:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [7:0] shift_q;
   reg byte_idx_q;
   reg ack_q;
   reg sync_hit_q;
   reg [2:0] cmd_q;
   reg [2:0] cmd_applied_q;
   reg [7:0] low_in_q;
   // Low byte waits here until the high byte is acked, so a cut word leaves old data
   reg [7:0] low_tmp_q;
   reg [1:0] high_in_q;
   reg word_done_q;
   reg pending_q;
   reg cmd_pending_q;

   wire scl_rise = scl_s2_q & ~scl_prev_q;
   wire scl_fall = ~scl_s2_q & scl_prev_q;
   wire start_det = scl_s2_q & scl_prev_q & sda_prev_q & ~sda_s2_q;
   wire stop_det = scl_s2_q & scl_prev_q & ~sda_prev_q & sda_s2_q;
   wire [7:0] shift_d = {shift_q[6:0], sda_s2_q};

   // Address byte is answered for the sync address with either option bit,
   // and for the own address only with the write bit clear
   function addr_hit;
      input [7:0] b;
      input [6:0] own;
      begin
         addr_hit = (b[7:1] == `SYNC_ADDR) || (b[7:1] == own && !b[0]);
      end
   endfunction

   // Edges are found one clock after the second flop, so every pin event
   // is acted on three clocks late; SCL phases must outlast that delay
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         scl_prev_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else begin
         scl_s1_q <= i_scl;
         scl_s2_q <= scl_s1_q;
         scl_prev_q <= scl_s2_q;
         sda_s1_q <= i_sda;
         sda_s2_q <= sda_s1_q;
         sda_prev_q <= sda_s2_q;
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         byte_idx_q <= 1'b0;
         ack_q <= 1'b0;
         sync_hit_q <= 1'b0;
         cmd_q <= `CMD_RESET;
         cmd_applied_q <= `CMD_RESET;
         low_in_q <= 8'h00;
         low_tmp_q <= 8'h00;
         high_in_q <= 2'h0;
         word_done_q <= 1'b0;
         pending_q <= 1'b0;
         cmd_pending_q <= 1'b0;
         o_sda_out <= 1'b0;
         o_sda_oe <= 1'b0;
         o_dac_code <= `CODE_RESET;
         o_power_down <= 1'b0;
         o_internal_ref_select <= 1'b0;
         o_sync_update_mode <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
         o_sync_update_mode <= cmd_q[`CMD_SYNC_MODE_BIT];
         o_internal_ref_select <= cmd_q[`CMD_REF_SEL_BIT];
         if (start_det || stop_det) begin
            // Partial bytes are simply abandoned; only acked bytes were stored
            o_sda_oe <= 1'b0;
            ack_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 1'b0;
            state_q <= start_det ? ST_ADDR : ST_IDLE;
            if (stop_det && cmd_pending_q) begin
               o_power_down <= cmd_q[`CMD_POWER_DOWN_BIT];
               cmd_pending_q <= 1'b0;
            end
            if (stop_det && pending_q && !cmd_q[`CMD_SYNC_MODE_BIT]) begin
               o_dac_code <= {high_in_q, low_in_q};
               pending_q <= 1'b0;
            end
            word_done_q <= 1'b0;
         end else begin
            if (scl_rise && state_q != ST_IDLE && state_q != ST_SKIP) begin
               if (bit_cnt_q < `BITS_PER_BYTE) begin
                  shift_q <= shift_d;
                  bit_cnt_q <= bit_cnt_q + 4'h1;
               end else if (ack_q) begin
                  // Ninth rising edge: acked byte takes effect here
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (state_q == ST_ADDR && sync_hit_q) begin
                     if (!shift_q[0]) begin
                        // Clear wins over any pending word; command bits are kept
                        o_dac_code <= `CODE_RESET;
                        low_in_q <= 8'h00;
                        low_tmp_q <= 8'h00;
                        high_in_q <= 2'h0;
                        pending_q <= 1'b0;
                     end else if (cmd_q[`CMD_SYNC_MODE_BIT] && pending_q) begin
                        o_dac_code <= {high_in_q, low_in_q};
                        pending_q <= 1'b0;
                     end
                  end else if (state_q == ST_CMD) begin
                     cmd_q <= shift_q[2:0];
                     cmd_pending_q <= 1'b1;
                  end else if (state_q == ST_DATA && !byte_idx_q) begin
                     word_done_q <= 1'b0;
                     low_tmp_q <= shift_q;
                  end else if (state_q == ST_DATA) begin
                     // Both halves enter the input registers together
                     low_in_q <= low_tmp_q;
                     high_in_q <= shift_q[1:0];
                     word_done_q <= 1'b1;
                     pending_q <= 1'b1;
                  end
               end
            end
            if (scl_fall && state_q != ST_IDLE && state_q != ST_SKIP) begin
               if (bit_cnt_q == `BITS_PER_BYTE) begin
                  if (state_q == ST_ADDR) begin
                     sync_hit_q <= (shift_q[7:1] == `SYNC_ADDR);
                     ack_q <= addr_hit(shift_q, OWN_ADDR);
                     // Raised in the low phase before the ninth pulse
                     o_sda_oe <= addr_hit(shift_q, OWN_ADDR);
                     if (!addr_hit(shift_q, OWN_ADDR)) begin
                        state_q <= ST_SKIP;
                     end
                  end else begin
                     // No ack once the word is complete; extra bytes are refused
                     ack_q <= 1'b1;
                     o_sda_oe <= (state_q != ST_DATA) || !word_done_q;
                  end
               end else if (bit_cnt_q == `ACK_SLOT) begin
                  // Released only after the ninth pulse has fallen
                  o_sda_oe <= 1'b0;
                  ack_q <= 1'b0;
                  bit_cnt_q <= 4'h0;
                  if (state_q == ST_ADDR) begin
                     state_q <= sync_hit_q ? ST_SKIP : ST_CMD;
                  end else if (state_q == ST_CMD) begin
                     state_q <= ST_DATA;
                  end else if (!byte_idx_q) begin
                     byte_idx_q <= 1'b1;
                  end else begin
                     state_q <= ST_SKIP;
                  end
               end
            end
         end
      end
   end
endmodule

// [bench/smbus_dac_rx_checker.sv]
// Checker of the receiver's acknowledge and latch timing.
// Assumes SCL phases of at least four clocks.
`timescale 1ns/1ps
module smbus_dac_rx_checker(
   input wire i_clk,
   input wire i_rst_n,
   input wire i_scl,
   input wire i_sda,
   input wire o_sda_out,
   input wire o_sda_oe,
   input wire [9:0] o_dac_code,
   input wire o_power_down,
   input wire o_internal_ref_select,
   input wire o_sync_update_mode);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_ack_pulls_low: assert property (o_sda_oe |-> !o_sda_out) else $error("ack drives high");
   a_ack_stands: assert property (o_sda_oe && i_scl |=> o_sda_oe) else $error("ack dropped early");
   a_ack_starts_low: assert property ($rose(o_sda_oe) |-> !i_scl) else $error("ack rose in high");
   a_ack_ends_low: assert property ($fell(o_sda_oe) |-> !i_scl) else $error("ack fell in high");
   a_ack_bounded: assert property ($rose(o_sda_oe) |-> ##[1:12] !o_sda_oe) else $error("ack too long");
   a_code_update_time: assert property ($changed(o_dac_code) |-> i_scl && (i_sda || o_sda_oe))
      else $error("code moved off stop or ack");
   a_pd_on_stop: assert property ($changed(o_power_down) |-> i_scl && i_sda) else $error("pd off stop");
   a_ref_on_ack: assert property ($changed(o_internal_ref_select) |-> o_sda_oe) else $error("ref off ack");
   a_mode_on_ack: assert property ($changed(o_sync_update_mode) |-> o_sda_oe) else $error("mode off ack");
   cover property ($changed(o_dac_code));
   cover property ($rose(o_power_down));
   cover property ($rose(o_sync_update_mode));
endmodule
bind smbus_dac_rx smbus_dac_rx_checker chk_u(.i_clk, .i_rst_n, .i_scl, .i_sda, .o_sda_out, .o_sda_oe,
   .o_dac_code, .o_power_down, .o_internal_ref_select, .o_sync_update_mode);

// [bench/smbus_host_model.sv]
// Open-drain host master, 800 ns per SCL bit.
// Assumes a pull-up on SDA; o_sda_low pulls it down.
`timescale 1ns/1ps
module smbus_host_model(
   input wire i_clk,
   input wire i_sda,
   output reg o_scl,
   output reg o_sda_low);
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task wait_n(input integer n);
      repeat (n) @(posedge i_clk);
   endtask
   task bit_io(input b, output r);
      begin
         o_scl <= 1'b0;
         wait_n(2);
         o_sda_low <= !b;
         wait_n(2);
         o_scl <= 1'b1;
         wait_n(4);
         r = i_sda;
      end
   endtask
   // s high gives START, low gives STOP
   task cond(input s);
      begin
         o_scl <= 1'b0;
         wait_n(2);
         o_sda_low <= !s;
         wait_n(2);
         o_scl <= 1'b1;
         wait_n(4);
         o_sda_low <= s;
         wait_n(4);
      end
   endtask
   task send_byte(input [7:0] b, output ack);
      integer i;
      reg r;
      begin
         for (i = 7; i >= 0; i = i - 1) bit_io(b[i], r);
         bit_io(1'b1, r);
         ack = !r;
      end
   endtask
endmodule

// [bench/test_smbus_dac_word_and_sync_receiver.sv]
// Bench: word, command-only, interrupted, foreign and sync frames.
// Assumes the host model drives SCL and SDA.
`timescale 1ns/1ps
`include "smbus_dac_map.vh"
module test_smbus_dac_word_and_sync_receiver;
   reg i_clk;
   reg i_rst_n = 1'b0;
   wire scl, sda_low, sda_out, sda_oe, pd, ref_sel, mode;
   wire [9:0] code;
   wire sda = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   integer failures = 0;
   integer total_checks = 0;
   integer cycles = 0;
   smbus_host_model host_u(.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   smbus_dac_rx dut_u(.i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe), .o_dac_code(code), .o_power_down(pd), .o_internal_ref_select(ref_sel),
      .o_sync_update_mode(mode));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task check(input [9:0] seen, input [9:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d failures %0d", total_checks, failures);
         if (failures == 0 && total_checks > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task put(input [7:0] b, input e);
      reg a;
      begin
         host_u.send_byte(b, a);
         check(a, e);
      end
   endtask
   task opn(input [7:0] b);
      begin
         host_u.cond(1'b1);
         put(b, 1'b1);
      end
   endtask
   task word_write;
      begin
         opn({`OWN_ADDR_DEFAULT, 1'b0});
         put(8'h06, 1'b1);
         put(8'hA5, 1'b1);
         put(8'hFE, 1'b1);
         check(pd, 10'h000);
         host_u.cond(1'b0);
         check(code, 10'h2A5);
         check({pd, ref_sel, mode}, 10'h006);
      end
   endtask
   task sync_update;
      begin
         opn({`OWN_ADDR_DEFAULT, 1'b0});
         put(8'h01, 1'b1);
         host_u.cond(1'b0);
         check(mode, 10'h001);
         check(code, 10'h2A5);
         opn({`OWN_ADDR_DEFAULT, 1'b0});
         put(8'h01, 1'b1);
         put(8'h3C, 1'b1);
         put(8'h01, 1'b1);
         host_u.cond(1'b0);
         check(code, 10'h2A5);
         opn({`SYNC_ADDR, 1'b1});
         host_u.cond(1'b0);
         check(code, 10'h13C);
      end
   endtask
   task interrupted;
      integer i;
      reg r;
      begin
         opn({`OWN_ADDR_DEFAULT, 1'b0});
         for (i = 0; i < 7; i = i + 1) host_u.bit_io(1'b0, r);
         host_u.cond(1'b0);
         check(mode, 10'h001);
         opn({`OWN_ADDR_DEFAULT, 1'b0});
         put(8'h01, 1'b1);
         put(8'h7A, 1'b1);
         put(8'h02, 1'b1);
         host_u.cond(1'b0);
         check(code, 10'h13C);
         opn({`OWN_ADDR_DEFAULT, 1'b0});
         put(8'h05, 1'b1);
         put(8'h55, 1'b1);
         host_u.cond(1'b1);
         check({ref_sel, mode}, 10'h003);
         put({7'h21, 1'b0}, 1'b0);
         put(8'h07, 1'b0);
         host_u.cond(1'b0);
         check(code, 10'h13C);
         opn({`SYNC_ADDR, 1'b1});
         host_u.cond(1'b0);
         check(code, 10'h27A);
         opn({`SYNC_ADDR, 1'b0});
         host_u.cond(1'b0);
         check(code, 10'h000);
      end
   endtask
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      word_write;
      sync_update;
      interrupted;
      tally_and_finish;
   end
   // Runs take about 2000 clocks
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         tally_and_finish;
      end
   end
endmodule
